// File: hdl/scan_regs_params.svh
`ifndef SCAN_REGS_PARAMS_SVH
`define SCAN_REGS_PARAMS_SVH

// Register offsets (byte-wide registers, printed offsets used directly)
`define OFS_IMAGE_BYTE_PORT        8'h00
`define OFS_BUFFER_FILL_LEVEL      8'h01
`define OFS_INPUT_LINE_STATUS      8'h02
`define OFS_INDIRECT_TARGET_SELECT 8'h03
`define OFS_EDGE_MODE              8'h10
`define OFS_IRQ_STATUS             8'h11
`define OFS_IRQ_MASK               8'h12

// Field positions of indirect_target_select
`define TSEL_TARGET_LSB            0
`define TSEL_COLOUR_LSB            2
`define TSEL_PAUSE_BIT             4

// Field positions of irq status / mask
`define IRQ_INPUT_EVENT_BIT        0
`define IRQ_PAUSE_BIT              1
`define IRQ_UNDERRUN_BIT           2

// Reset values
`define RST_TARGET_SELECT          8'h00
`define RST_EDGE_MODE              8'h00
`define RST_IRQ_MASK               8'h00
`define RST_IRQ_STATUS             8'h00

// Buffer block sizes in bytes
`define BLOCK_BYTES_SMALL          2048
`define BLOCK_BYTES_LARGE          8192

`endif

// File: hdl/scan_regs_pkg.sv
package scan_regs_pkg;

   typedef enum logic [1:0] {
      TARGET_OFFSET = 2'h0,
      TARGET_GAIN   = 2'h1,
      TARGET_GAMMA  = 2'h2,
      TARGET_NONE   = 2'h3
   } target_sel_t;

   typedef enum logic [1:0] {
      COLOUR_RED   = 2'h0,
      COLOUR_GREEN = 2'h1,
      COLOUR_BLUE  = 2'h2,
      COLOUR_NONE  = 2'h3
   } colour_sel_t;

   typedef enum logic [2:0] {
      PORT_IDLE  = 3'b001,
      PORT_FETCH = 3'b010,
      PORT_READY = 3'b100
   } port_state_t;

endpackage : scan_regs_pkg

// File: hdl/image_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

interface image_stream_if;
   logic       pop;
   logic [7:0] data;
   logic       valid;
   logic       underrun;

   modport producer (
      input  pop,
      output data,
      output valid,
      output underrun
   );
   modport consumer (
      output pop,
      input  data,
      input  valid,
      input  underrun
   );
endinterface : image_stream_if

`default_nettype wire

// File: hdl/image_byte_fetch.sv
`timescale 1ns/100ps
`default_nettype none

// Holds the next image byte ready, so a register read returns it at once
module image_byte_fetch
   import scan_regs_pkg::*;
(
   // Clock and reset
   input  wire logic   clock_i,
   input  wire logic   rst_n_i,
   // Buffer side
   input  wire logic   buf_valid_i,
   input  wire logic [7:0] buf_data_i,
   output logic        buf_take_o,
   // Register side
   image_stream_if.producer stream
);

   port_state_t state_ff;
   port_state_t nxt_state;
   logic [7:0]  data_ff;
   logic        under_ff;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         PORT_IDLE:  if (buf_valid_i) nxt_state = PORT_FETCH;
         PORT_FETCH: nxt_state = PORT_READY;
         PORT_READY: if (stream.pop) nxt_state = PORT_IDLE;
         default:    nxt_state = PORT_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) state_ff <= PORT_IDLE;
      else          state_ff <= nxt_state;
   end

   // Registered take: the buffer pops its head at the edge that ends FETCH, where the byte is captured
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) buf_take_o <= 1'b0;
      else          buf_take_o <= (state_ff == PORT_IDLE) && buf_valid_i;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i)                  data_ff <= 8'h00;
      else if (state_ff == PORT_FETCH) data_ff <= buf_data_i;
   end

   // A pop with no byte held is flagged, never silently stretched
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) under_ff <= 1'b0;
      else          under_ff <= stream.pop && (state_ff != PORT_READY);
   end

   assign stream.data     = data_ff;
   assign stream.valid    = (state_ff == PORT_READY);
   assign stream.underrun = under_ff;

   property p_fetch_then_ready;
      @(posedge clock_i) disable iff (!rst_n_i)
      state_ff == PORT_FETCH |=> state_ff == PORT_READY;
   endproperty
   a_fetch_then_ready: assert property (p_fetch_then_ready) else $error("fetch did not reach ready");

endmodule : image_byte_fetch

`default_nettype wire

// File: hdl/input_edge_latch.sv
`timescale 1ns/100ps
`default_nettype none

// Per-line status: level image or latched edge, cleared by a status read
module input_edge_latch #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // Lines and configuration
   input  wire logic [WIDTH-1:0] lines_i,
   input  wire logic [WIDTH-1:0] edge_mode_i,
   input  wire logic             clear_i,
   // Results
   output logic      [WIDTH-1:0] status_o,
   output logic                  event_o
);

   logic [WIDTH-1:0] prev_ff;
   logic [WIDTH-1:0] seen_ff;
   logic [WIDTH-1:0] rise;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) prev_ff <= '0;
      else          prev_ff <= lines_i;
   end

   assign rise = lines_i & ~prev_ff;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_line
         // A new edge in the clearing cycle wins over the clear
         always_ff @(posedge clock_i) begin
            if (!rst_n_i)      seen_ff[g] <= 1'b0;
            else if (rise[g])  seen_ff[g] <= 1'b1;
            else if (clear_i)  seen_ff[g] <= 1'b0;
         end
         assign status_o[g] = edge_mode_i[g] ? seen_ff[g] : lines_i[g];
      end
   endgenerate

   assign event_o = |(rise & edge_mode_i);

endmodule : input_edge_latch

`default_nettype wire

// File: hdl/scanner_status_dataport_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "scan_regs_params.svh"

module scanner_status_dataport_regs
   import scan_regs_pkg::*;
#(
   parameter int BUF_BYTES_W = 24
) (
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // Register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // Image buffer
   input  wire logic       buf_valid_i,
   input  wire logic [7:0] buf_data_i,
   output logic            buf_take_o,
   input  wire logic [BUF_BYTES_W-1:0] buf_bytes_i,
   input  wire logic       buf_large_i,
   input  wire logic       scan_paused_i,
   // Input lines
   input  wire logic       media_detect_in_a_i,
   input  wire logic       media_detect_in_b_i,
   input  wire logic [5:0] gpio_in_i,
   // Indirect access selection
   output target_sel_t     target_o,
   output colour_sel_t     colour_o,
   // Interrupt
   output logic            irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction : hit

   logic rd_image;
   logic rd_status;
   logic wr_tsel;
   logic wr_edge;
   logic wr_istat;
   logic wr_imask;

   assign rd_image  = rd_i && hit(addr_i, `OFS_IMAGE_BYTE_PORT);
   assign rd_status = rd_i && hit(addr_i, `OFS_INPUT_LINE_STATUS);
   assign wr_tsel   = wr_i && hit(addr_i, `OFS_INDIRECT_TARGET_SELECT);
   assign wr_edge   = wr_i && hit(addr_i, `OFS_EDGE_MODE);
   assign wr_istat  = wr_i && hit(addr_i, `OFS_IRQ_STATUS);
   assign wr_imask  = wr_i && hit(addr_i, `OFS_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // Image byte port

   image_stream_if stream ();

   assign stream.pop = rd_image;

   image_byte_fetch u_fetch (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .buf_valid_i (buf_valid_i),
      .buf_data_i  (buf_data_i),
      .buf_take_o  (buf_take_o),
      .stream      (stream)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Fill level, in whole blocks of the fitted buffer size

   localparam int SHIFT_SMALL = $clog2(`BLOCK_BYTES_SMALL);
   localparam int SHIFT_LARGE = $clog2(`BLOCK_BYTES_LARGE);

   logic [BUF_BYTES_W-1:0] blocks;
   logic [7:0]             fill_level;

   always_comb begin
      blocks = buf_large_i ? (buf_bytes_i >> SHIFT_LARGE) : (buf_bytes_i >> SHIFT_SMALL);
      // Saturate rather than wrap when the count outgrows the byte
      fill_level = (|blocks[BUF_BYTES_W-1:8]) ? 8'hFF : blocks[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input line status

   logic [7:0] edge_mode_ff;
   logic [7:0] line_status;
   logic       line_event;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i)     edge_mode_ff <= `RST_EDGE_MODE;
      else if (wr_edge) edge_mode_ff <= wdata_i;
   end

   input_edge_latch #(
      .WIDTH (8)
   ) u_lines (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .lines_i     ({gpio_in_i, media_detect_in_b_i, media_detect_in_a_i}),
      .edge_mode_i (edge_mode_ff),
      .clear_i     (rd_status),
      .status_o    (line_status),
      .event_o     (line_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Indirect target and colour

   logic [3:0] tsel_ff;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i)     tsel_ff <= 4'(`RST_TARGET_SELECT);
      else if (wr_tsel) tsel_ff <= wdata_i[3:0];
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         target_o <= TARGET_OFFSET;
         colour_o <= COLOUR_RED;
      end else begin
         target_o <= target_sel_t'(tsel_ff[`TSEL_TARGET_LSB +: 2]);
         colour_o <= colour_sel_t'(tsel_ff[`TSEL_COLOUR_LSB +: 2]);
      end
   end

   logic pause_ff;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) pause_ff <= 1'b0;
      else          pause_ff <= scan_paused_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   logic [2:0] irq_stat_ff;
   logic [2:0] irq_mask_ff;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic [2:0] nxt_irq_stat;
   logic       pause_rise;

   assign pause_rise   = scan_paused_i && !pause_ff;
   assign irq_set      = {stream.underrun, pause_rise, line_event};
   assign irq_clr      = wr_istat ? wdata_i[2:0] : 3'h0;
   // A set in the clearing cycle wins
   assign nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i)       irq_mask_ff <= 3'(`RST_IRQ_MASK);
      else if (wr_imask)  irq_mask_ff <= wdata_i[2:0];
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) irq_stat_ff <= 3'(`RST_IRQ_STATUS);
      else          irq_stat_ff <= nxt_irq_stat;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) irq_o <= 1'b0;
      else          irq_o <= |(irq_mask_ff & nxt_irq_stat);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe; unmapped offsets read zero

   logic [7:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            `OFS_IMAGE_BYTE_PORT:        nxt_rdata = stream.data;
            `OFS_BUFFER_FILL_LEVEL:      nxt_rdata = fill_level;
            `OFS_INPUT_LINE_STATUS:      nxt_rdata = line_status;
            `OFS_INDIRECT_TARGET_SELECT: nxt_rdata = {3'h0, pause_ff, tsel_ff};
            `OFS_EDGE_MODE:              nxt_rdata = edge_mode_ff;
            `OFS_IRQ_STATUS:             nxt_rdata = {5'h00, irq_stat_ff};
            `OFS_IRQ_MASK:               nxt_rdata = {5'h00, irq_mask_ff};
            default:                     nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) rdata_o <= 8'h00;
      else          rdata_o <= nxt_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_image_read;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_image && stream.valid |=> rdata_o == $past(stream.data);
   endproperty
   a_image_read: assert property (p_image_read) else $error("image byte not returned");

   property p_fill_small;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_i && addr_i == `OFS_BUFFER_FILL_LEVEL && !buf_large_i && buf_bytes_i < 24'h080000
      |=> rdata_o == 8'($past(buf_bytes_i) >> 11);
   endproperty
   a_fill_small: assert property (p_fill_small) else $error("fill level wrong");

   property p_level_lines;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_status && edge_mode_ff == 8'h00
      |=> rdata_o == $past({gpio_in_i, media_detect_in_b_i, media_detect_in_a_i});
   endproperty
   a_level_lines: assert property (p_level_lines) else $error("line status wrong");

   property p_edge_clear;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_status && edge_mode_ff[0] && !u_lines.rise[0] |=> !u_lines.seen_ff[0];
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("edge bit not cleared");

   property p_target;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_tsel ##2 1 |-> target_o == target_sel_t'($past(wdata_i[1:0], 2));
   endproperty
   a_target: assert property (p_target) else $error("target select wrong");

   property p_pause_low;
      @(posedge clock_i) disable iff (!rst_n_i)
      !scan_paused_i && rd_i && addr_i == `OFS_INDIRECT_TARGET_SELECT && !pause_ff |=> !rdata_o[4];
   endproperty
   a_pause_low: assert property (p_pause_low) else $error("pause flag set while running");

   property p_pause_high;
      @(posedge clock_i) disable iff (!rst_n_i)
      scan_paused_i ##1 rd_i && addr_i == `OFS_INDIRECT_TARGET_SELECT |=> rdata_o[4];
   endproperty
   a_pause_high: assert property (p_pause_high) else $error("pause flag missing");

   property p_reset_vals;
      @(posedge clock_i) !rst_n_i |=> tsel_ff == 4'h0 && edge_mode_ff == 8'h00 && !irq_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

   property p_colour;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_tsel ##2 1 |-> colour_o == colour_sel_t'($past(wdata_i[3:2], 2));
   endproperty
   a_colour: assert property (p_colour) else $error("colour select wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Register and interrupt checks

   property p_tsel_wr;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_tsel |=> tsel_ff == $past(wdata_i[3:0]);
   endproperty
   a_tsel_wr: assert property (p_tsel_wr) else $error("target register not written");

   property p_edge_mode_wr;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_edge |=> edge_mode_ff == $past(wdata_i);
   endproperty
   a_edge_mode_wr: assert property (p_edge_mode_wr) else $error("edge mode not written");

   property p_fill_large;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_i && addr_i == `OFS_BUFFER_FILL_LEVEL && buf_large_i && buf_bytes_i < 24'h200000
      |=> rdata_o == 8'($past(buf_bytes_i) >> 13);
   endproperty
   a_fill_large: assert property (p_fill_large) else $error("large fill level wrong");

   property p_rdata_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !rd_i |=> rdata_o == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero without a read");

   property p_unmapped;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_i && addr_i > `OFS_IRQ_MASK |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped offset read not zero");

   property p_edge_latch;
      @(posedge clock_i) disable iff (!rst_n_i)
      edge_mode_ff[2] && u_lines.rise[2] && !wr_edge |=> line_status[2];
   endproperty
   a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");

   property p_image_pop;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_image && stream.valid |=> !stream.valid;
   endproperty
   a_image_pop: assert property (p_image_pop) else $error("image byte not consumed");

   property p_take_pulse;
      @(posedge clock_i) disable iff (!rst_n_i)
      buf_take_o |=> !buf_take_o;
   endproperty
   a_take_pulse: assert property (p_take_pulse) else $error("buffer take longer than a cycle");

   property p_irq_level;
      @(posedge clock_i) disable iff (!rst_n_i)
      irq_o == |($past(irq_mask_ff) & irq_stat_ff);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   property p_irq_w1c;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_istat && wdata_i[`IRQ_INPUT_EVENT_BIT] && !irq_set[`IRQ_INPUT_EVENT_BIT] |=> !irq_stat_ff[`IRQ_INPUT_EVENT_BIT];
   endproperty
   a_irq_w1c: assert property (p_irq_w1c) else $error("status bit not cleared by write");

   property p_irq_sticky;
      @(posedge clock_i) disable iff (!rst_n_i)
      irq_stat_ff[`IRQ_INPUT_EVENT_BIT] && !irq_clr[`IRQ_INPUT_EVENT_BIT] |=> irq_stat_ff[`IRQ_INPUT_EVENT_BIT];
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("status bit lost");

   property p_underrun_irq;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_image && !stream.valid |-> ##2 irq_stat_ff[`IRQ_UNDERRUN_BIT];
   endproperty
   a_underrun_irq: assert property (p_underrun_irq) else $error("underrun not flagged");

   property p_pause_irq;
      @(posedge clock_i) disable iff (!rst_n_i)
      pause_rise |=> irq_stat_ff[`IRQ_PAUSE_BIT];
   endproperty
   a_pause_irq: assert property (p_pause_irq) else $error("pause event not flagged");

   c_image_read: cover property (@(posedge clock_i) disable iff (!rst_n_i) rd_image && stream.valid);
   c_edge_read:  cover property (@(posedge clock_i) disable iff (!rst_n_i) rd_status && |(line_status & edge_mode_ff));
   c_pause:      cover property (@(posedge clock_i) disable iff (!rst_n_i) pause_rise);
   c_irq:        cover property (@(posedge clock_i) disable iff (!rst_n_i) irq_o);
   c_underrun:   cover property (@(posedge clock_i) disable iff (!rst_n_i) rd_image && !stream.valid);

endmodule : scanner_status_dataport_regs

`default_nettype wire

// File: test/scanner_status_dataport_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module scanner_status_dataport_regs_tb
   import scan_regs_pkg::*;
;
   logic        clock_i;
   logic        rst_n_i;
   logic [7:0]  addr_i;
   logic [7:0]  wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [7:0]  rdata_o;
   logic        buf_valid_i;
   logic [7:0]  buf_data_i;
   logic        buf_take_o;
   logic [23:0] buf_bytes_i;
   logic        buf_large_i;
   logic        scan_paused_i;
   logic        media_detect_in_a_i;
   logic        media_detect_in_b_i;
   logic [5:0]  gpio_in_i;
   target_sel_t target_o;
   colour_sel_t colour_o;
   logic        irq_o;
   int          n_errors;
   int          samples_checked;
   logic [7:0]  rd_val;
   logic [7:0]  buf_idx;
   logic [24:0] fill_tab [4];

   scanner_status_dataport_regs #(.BUF_BYTES_W(24)) i_scanner_status_dataport_regs (
      .clock_i             (clock_i),
      .rst_n_i             (rst_n_i),
      .addr_i              (addr_i),
      .wdata_i             (wdata_i),
      .wr_i                (wr_i),
      .rd_i                (rd_i),
      .rdata_o             (rdata_o),
      .buf_valid_i         (buf_valid_i),
      .buf_data_i          (buf_data_i),
      .buf_take_o          (buf_take_o),
      .buf_bytes_i         (buf_bytes_i),
      .buf_large_i         (buf_large_i),
      .scan_paused_i       (scan_paused_i),
      .media_detect_in_a_i (media_detect_in_a_i),
      .media_detect_in_b_i (media_detect_in_b_i),
      .gpio_in_i           (gpio_in_i),
      .target_o            (target_o),
      .colour_o            (colour_o),
      .irq_o               (irq_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and a four-byte image buffer that advances when the head is taken
   always #25 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      if (buf_take_o === 1'b1)
         buf_idx <= buf_idx + 8'h01;
   end
   assign buf_data_i  = 8'hA0 + buf_idx;
   assign buf_valid_i = (buf_idx < 8'h04);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic ck(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : ck

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i   <= 1'b0;
      #1;
      rd_val = rdata_o;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : settle

   task automatic finish_test;
      $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      finish_test();
   end

   initial begin
      clock_i = 1'b0; rst_n_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
      wr_i = 1'b0; rd_i = 1'b0; buf_idx = 8'h00; buf_bytes_i = 24'h000000;
      buf_large_i = 1'b0; scan_paused_i = 1'b0; media_detect_in_a_i = 1'b0;
      media_detect_in_b_i = 1'b0; gpio_in_i = 6'h00;
      n_errors = 0; samples_checked = 0;
      fill_tab[0] = {1'b0, 24'h0007FF};
      fill_tab[1] = {1'b0, 24'h000800};
      fill_tab[2] = {1'b1, 24'h001FFF};
      fill_tab[3] = {1'b1, 24'h1FE000};
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;

      // Power-up defaults
      settle(1);
      ck("target", {6'h00, target_o}, 8'h00);
      ck("colour", {6'h00, colour_o}, 8'h00);
      ck("irq", {7'h00, irq_o}, 8'h00);
      rd(8'h03); ck("tsel", rd_val, 8'h00);
      rd(8'h10); ck("edge_mode", rd_val, 8'h00);
      rd(8'h11); ck("irq_status", rd_val, 8'h00);
      rd(8'h12); ck("irq_mask", rd_val, 8'h00);
      rd(8'h20); ck("unmapped", rd_val, 8'h00);
      $display("Test reset defaults done");

      // Level status bits
      media_detect_in_a_i <= 1'b1;
      gpio_in_i <= 6'h2A;
      settle(3);
      rd(8'h02); ck("status_level", rd_val, 8'hA9);
      $display("Test level status done");

      // Fill level in both block sizes, and a write to it ignored
      wr(8'h01, 8'h55);
      for (int i = 0; i < 4; i++) begin
         buf_large_i <= fill_tab[i][24];
         buf_bytes_i <= fill_tab[i][23:0];
         settle(2);
         rd(8'h01);
         ck("fill", rd_val, (i == 3) ? 8'hFF : ((i == 1) ? 8'h01 : 8'h00));
      end
      buf_bytes_i <= 24'h7FF800;
      buf_large_i <= 1'b0;
      settle(2);
      rd(8'h01); ck("fill_sat", rd_val, 8'hFF);
      $display("Test fill level done");

      // Every target and colour code
      for (int c = 0; c < 4; c++) begin
         for (int t = 0; t < 4; t++) begin
            wr(8'h03, {4'h1, c[1:0], t[1:0]});
            settle(2);
            ck("target", {6'h00, target_o}, {6'h00, t[1:0]});
            ck("colour", {6'h00, colour_o}, {6'h00, c[1:0]});
            rd(8'h03); ck("tsel", rd_val, {4'h0, c[1:0], t[1:0]});
         end
      end
      $display("Test target select done");

      // Pause flag follows a buffer-full hold
      scan_paused_i <= 1'b1;
      settle(3);
      rd(8'h03); ck("pause_on", rd_val, 8'h1F);
      scan_paused_i <= 1'b0;
      settle(3);
      rd(8'h03); ck("pause_off", rd_val, 8'h0F);
      rd(8'h11); ck("irq_pause", rd_val, 8'h02);
      $display("Test pause flag done");

      // Edge-latched bits, clear on read, interrupt raise, mask and clear
      media_detect_in_a_i <= 1'b0;
      gpio_in_i <= 6'h00;
      wr(8'h11, 8'hFF);
      wr(8'h10, 8'hFF);
      settle(3);
      rd(8'h02);
      media_detect_in_a_i <= 1'b1;
      gpio_in_i <= 6'h01;
      settle(2);
      media_detect_in_a_i <= 1'b0;
      gpio_in_i <= 6'h00;
      settle(3);
      rd(8'h02); ck("status_edge", rd_val, 8'h05);
      rd(8'h02); ck("status_clr", rd_val, 8'h00);
      rd(8'h11); ck("irq_evt", rd_val, 8'h01);
      ck("irq_masked", {7'h00, irq_o}, 8'h00);
      wr(8'h12, 8'h01);
      settle(2);
      ck("irq_on", {7'h00, irq_o}, 8'h01);
      wr(8'h11, 8'h01);
      settle(2);
      ck("irq_off", {7'h00, irq_o}, 8'h00);
      rd(8'h11); ck("irq_w1c", rd_val, 8'h00);
      $display("Test edge latch and interrupt done");

      // Image bytes in order, write ignored, then underrun
      wr(8'h00, 8'h33);
      settle(4);
      for (int i = 0; i < 4; i++) begin
         rd(8'h00); ck("image", rd_val, 8'hA0 + 8'(i));
         settle(4);
      end
      rd(8'h00);
      rd(8'h11); ck("underrun", rd_val & 8'h04, 8'h04);
      $display("Test image port done");

      finish_test();
   end
endmodule : scanner_status_dataport_regs_tb

`default_nettype wire
